// ---- src/ipc_pkg.sv ----
// Constants and types for the idle and power-down controller
package ipc_pkg;
    localparam logic [7:0] PWR_CTRL_ADDR  = 8'h87;
    localparam int         IDLE_BIT_POS   = 0;
    localparam int         PDN_BIT_POS    = 1;
    localparam int         UF0_BIT_POS    = 2;
    localparam int         UF1_BIT_POS    = 3;
    localparam int         POF_BIT_POS    = 4;
    localparam int         SMOD0_BIT_POS  = 6;
    localparam int         SMOD1_BIT_POS  = 7;
    localparam logic [7:0] PWR_CTRL_RESET = 8'h10;
    localparam logic [7:0] PWR_CTRL_WMASK = 8'hdf;
    localparam logic [7:0] PORT_RESET_VAL = 8'hff;
    localparam int         WARM_RST_CYC   = 24;
    localparam int         OSC_STAB_NS    = 200;
    localparam int         CLK_PERIOD_NS  = 50;
    localparam int         OSC_STAB_CYC   = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         RAM_BLOCK_CYC  = 4;

    typedef enum logic [2:0]
    {
        ST_RUN,
        ST_IDLE,
        ST_PDOWN,
        ST_OSC_WAIT,
        ST_IRQ_HOLD,
        ST_RST_RESUME
    } ipc_state_t;
endpackage

// ---- src/ipc_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ipc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             core_clk,  // Clock
    input  wire logic             rst_n,     // Sync reset
    input  wire logic             clk_en,    // Clock enable
    input  wire logic [WIDTH-1:0] din,       // Asynchronous input
    output logic      [WIDTH-1:0] dout       // Synchronised output
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= INIT;
            dout    <= INIT;
        end
        else if (clk_en)
        begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

// ---- src/ipc_top.sv ----
// Idle and power-down mode controller with power control register
//
// Behaviour
// - Idle gates CPU clock, peripherals keep running
// - Idle keeps PC, status, registers, RAM
// - Idle begins when setting instruction completes
// - Both bits set means power-down only
// - Enabled interrupt clears idle, resumes CPU
// - Reset pin clears idle, restores CPU clock
// - Block RAM while resuming after reset wake
// - Converter completion ends converter-requested idle
// - Power-down stops oscillator, freezes all clocks
// - Power-down begins when setting instruction completes
// - Enabled external interrupt ends power-down
// - Hold execution until external interrupt released
// - Interrupt wake leaves registers and RAM
// - Reset pin clears power-down, restarts oscillator
// - Reset exit reinitialises registers, keeps RAM
// - Ports high in reset, latched otherwise
// - Register bit0 idle, bit1 power-down
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module ipc_top
    import ipc_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input  wire logic              core_clk,          // 20 MHz clock
    input  wire logic              rst_n,             // Sync reset, active low
    input  wire logic              clk_en,            // Freezes all state when low
    input  wire logic [7:0]        reg_addr,          // Register address
    input  wire logic [7:0]        reg_wdata,         // Write data
    input  wire logic              reg_wr,            // Write strobe
    input  wire logic              reg_rd,            // Read strobe
    output logic      [7:0]        reg_rdata,         // Read data, one cycle later
    input  wire logic              instr_done,        // CPU instruction completes
    input  wire logic              rst_pin,           // Reset pin, active high
    input  wire logic              external_irq_zero_n, // External interrupt 0 pin
    input  wire logic              external_irq_one_n,  // External interrupt 1 pin
    input  wire logic [1:0]        ext_irq_en,        // Individual enables, ext 0/1
    input  wire logic              irq_req,           // Any pending interrupt source
    input  wire logic              irq_src_en,        // That source individually enabled
    input  wire logic              irq_global_en,     // Global interrupt enable
    input  wire logic              adc_idle_req,      // Idle requested by converter option
    input  wire logic              adc_done,          // Converter completion pulse
    input  wire logic              osc_ready,         // Oscillator stable
    input  wire logic [PORT_W-1:0] port_latch,        // Port latched data
    output logic                   cpu_clk_en,        // CPU clock enable
    output logic                   periph_clk_en,     // Peripheral clock enable
    output logic                   osc_en,            // Oscillator run
    output logic                   cpu_hold,          // Holds instruction execution
    output logic                   ram_block,         // Blocks internal RAM access
    output logic                   sfr_reset,         // Reinitialise special registers
    output logic                   int_rst,           // Internal reset to CPU
    output logic                   wake_irq,          // Wake by interrupt pulse
    output logic [PORT_W-1:0]      port_out,          // Port pin levels
    output logic [PORT_W-1:0]      port_oe_n,         // Port drive enable, low drives
    output logic [2:0]             mode_state         // Current mode
);
    ipc_state_t  state_ff;
    ipc_state_t  nxt_state;
    logic [7:0]  pwr_ctrl_ff;
    logic [7:0]  nxt_pwr_ctrl;
    logic        rst_s;
    logic [1:0]  ext_s_n;
    logic        ext_active;
    logic        idle_wake;
    logic        adc_idle_ff;
    logic [7:0]  rst_cnt_ff;
    logic [7:0]  wait_cnt_ff;
    logic        rst_seq;
    logic        pwr_ctrl_wr;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == PWR_CTRL_ADDR);
    endfunction

    ipc_sync #(.WIDTH(3), .INIT(3'h6)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .din      ({external_irq_one_n, external_irq_zero_n, rst_pin}),
        .dout     ({ext_s_n, rst_s})
    );

    assign pwr_ctrl_wr = reg_wr && reg_hit(reg_addr);
    assign ext_active = (!ext_s_n[0] && ext_irq_en[0]) || (!ext_s_n[1] && ext_irq_en[1]);
    assign idle_wake  = irq_req && irq_src_en && irq_global_en;
    assign rst_seq    = rst_cnt_ff != 8'h00;

    // Mode sequencing
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:
                if (rst_s)
                    nxt_state = ST_RUN;
                else if (instr_done && pwr_ctrl_ff[PDN_BIT_POS])
                    nxt_state = ST_PDOWN;
                else if (instr_done && pwr_ctrl_ff[IDLE_BIT_POS])
                    nxt_state = ST_IDLE;
            ST_IDLE:
                if (rst_s)
                    nxt_state = ST_RST_RESUME;
                else if (idle_wake || (adc_idle_ff && adc_done))
                    nxt_state = ST_RUN;
            ST_PDOWN:
                if (rst_s)
                    nxt_state = ST_RST_RESUME;
                else if (ext_active)
                    nxt_state = ST_OSC_WAIT;
            ST_OSC_WAIT:
                if (rst_s)
                    nxt_state = ST_RST_RESUME;
                else if (osc_ready && wait_cnt_ff >= 8'(OSC_STAB_CYC))
                    nxt_state = ST_IRQ_HOLD;
            ST_IRQ_HOLD:
                if (rst_s)
                    nxt_state = ST_RST_RESUME;
                else if (!ext_active)
                    nxt_state = ST_RUN;
            ST_RST_RESUME:
                if (wait_cnt_ff >= 8'(RAM_BLOCK_CYC))
                    nxt_state = ST_RUN;
            default:
                nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            state_ff <= ST_RUN;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // Cycle counter for oscillator start and reset resume windows
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            wait_cnt_ff <= 8'h00;
        else if (clk_en)
        begin
            if (nxt_state != state_ff)
                wait_cnt_ff <= 8'h00;
            else if (wait_cnt_ff != 8'hff)
                wait_cnt_ff <= wait_cnt_ff + 8'h01;
        end
    end

    // Captures converter idle option at idle entry
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            adc_idle_ff <= 1'b0;
        else if (clk_en && state_ff == ST_RUN && nxt_state == ST_IDLE)
            adc_idle_ff <= adc_idle_req;
        else if (clk_en && state_ff != ST_IDLE)
            adc_idle_ff <= 1'b0;
    end

    // Internal reset sequence after reset pin release
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rst_cnt_ff <= 8'h00;
        else if (clk_en)
        begin
            if (rst_s && state_ff != ST_IDLE && state_ff != ST_PDOWN)
                rst_cnt_ff <= 8'(WARM_RST_CYC);
            else if (rst_seq)
                rst_cnt_ff <= rst_cnt_ff - 8'h01;
        end
    end

    // Power control register
    always_comb
    begin
        nxt_pwr_ctrl = pwr_ctrl_ff;
        if (pwr_ctrl_wr)
            nxt_pwr_ctrl = (reg_wdata & PWR_CTRL_WMASK) | (pwr_ctrl_ff & ~PWR_CTRL_WMASK);
        if (state_ff == ST_IDLE && nxt_state == ST_RUN)
            nxt_pwr_ctrl[IDLE_BIT_POS] = 1'b0;
        if (state_ff == ST_RUN && nxt_state == ST_PDOWN)
            nxt_pwr_ctrl[IDLE_BIT_POS] = 1'b0;
        if (state_ff == ST_PDOWN && nxt_state == ST_OSC_WAIT)
            nxt_pwr_ctrl[PDN_BIT_POS] = 1'b0;
        if (rst_s)
        begin
            nxt_pwr_ctrl[IDLE_BIT_POS] = 1'b0;
            nxt_pwr_ctrl[PDN_BIT_POS]  = 1'b0;
        end
        if (rst_seq && !rst_s)
        begin
            nxt_pwr_ctrl = PWR_CTRL_RESET & ~(8'h01 << POF_BIT_POS);
            nxt_pwr_ctrl[POF_BIT_POS] = pwr_ctrl_ff[POF_BIT_POS];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pwr_ctrl_ff <= PWR_CTRL_RESET;
        else if (clk_en)
            pwr_ctrl_ff <= nxt_pwr_ctrl;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            if (reg_rd && reg_hit(reg_addr))
                reg_rdata <= pwr_ctrl_ff & PWR_CTRL_WMASK;
            else
                reg_rdata <= 8'h00;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            wake_irq <= 1'b0;
        else if (clk_en)
            wake_irq <= (state_ff == ST_IDLE && nxt_state == ST_RUN)
                      || (state_ff == ST_IRQ_HOLD && nxt_state == ST_RUN);
    end

    // Clock gates and holds
    always_comb
    begin
        cpu_clk_en    = 1'b1;
        periph_clk_en = 1'b1;
        osc_en        = 1'b1;
        cpu_hold      = 1'b0;
        ram_block     = 1'b0;
        case (state_ff)
            ST_IDLE:
                cpu_clk_en = 1'b0;
            ST_PDOWN:
            begin
                cpu_clk_en    = 1'b0;
                periph_clk_en = 1'b0;
                osc_en        = 1'b0;
            end
            ST_OSC_WAIT:
            begin
                cpu_clk_en    = 1'b0;
                periph_clk_en = 1'b0;
            end
            ST_IRQ_HOLD:
                cpu_hold = 1'b1;
            ST_RST_RESUME:
                ram_block = 1'b1;
            default:
                cpu_clk_en = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            port_out <= {PORT_W{1'b1}};
            int_rst  <= 1'b1;
        end
        else if (clk_en)
        begin
            int_rst <= rst_s || rst_seq;
            if (rst_s || rst_seq)
                port_out <= {PORT_W{1'b1}};
            else
                port_out <= port_latch;
        end
    end

    assign sfr_reset  = int_rst;
    assign port_oe_n  = {PORT_W{1'b0}};
    assign mode_state = state_ff;
endmodule

// ---- verif/ipc_assertions.sv ----
// Concurrent checks on the idle and power-down controller ports
`timescale 1ns/1ps
module ipc_assertions
    import ipc_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic              core_clk,      // Clock
    input wire logic              rst_n,         // Sync reset
    input wire logic              clk_en,        // Clock enable
    input wire logic [7:0]        reg_addr,      // Address
    input wire logic              reg_rd,        // Read strobe
    input wire logic [7:0]        reg_rdata,     // Read data
    input wire logic              irq_req,       // Pending source
    input wire logic              irq_src_en,    // Source enable
    input wire logic              irq_global_en, // Global enable
    input wire logic              cpu_clk_en,    // CPU clock
    input wire logic              periph_clk_en, // Peripheral clock
    input wire logic              osc_en,        // Oscillator run
    input wire logic              cpu_hold,      // Execution hold
    input wire logic              ram_block,     // RAM blocked
    input wire logic              wake_irq,      // Wake pulse
    input wire logic [PORT_W-1:0] port_out,      // Port levels
    input wire logic [2:0]        mode_state     // Mode
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence idle_irq_s;
        clk_en && mode_state == ST_IDLE && irq_req && irq_src_en && irq_global_en;
    endsequence

    a_idle_cpu_gated: assert property (mode_state == ST_IDLE
        |-> !cpu_clk_en && periph_clk_en) else $error("cpu clock runs in idle");
    a_pdown_clocks_off: assert property (mode_state == ST_PDOWN
        |-> !osc_en && !cpu_clk_en && !periph_clk_en) else $error("clock runs in power-down");
    a_idle_irq_wake: assert property (idle_irq_s
        |=> mode_state inside {ST_RUN, ST_RST_RESUME}) else $error("idle not left on irq");
    a_wake_pulse_follows: assert property (idle_irq_s
        |=> mode_state == ST_RUN && wake_irq) else $error("no wake pulse");
    a_hold_until_release: assert property (mode_state == ST_IRQ_HOLD
        |-> cpu_hold && osc_en) else $error("execution not held");
    a_pdown_no_idle: assert property (mode_state inside {ST_OSC_WAIT, ST_IRQ_HOLD}
        |=> mode_state != ST_IDLE) else $error("idle after power-down");
    a_resume_ram_off: assert property (mode_state == ST_RST_RESUME
        |-> ram_block && cpu_clk_en) else $error("ram open while resuming");
    a_reset_ports_high: assert property (disable iff (1'h0) !rst_n && clk_en
        |=> port_out == {PORT_W{1'h1}}) else $error("port low in reset");
    a_unmapped_read_zero: assert property (clk_en && reg_rd && reg_addr != PWR_CTRL_ADDR
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");

    c_idle_wake: cover property (mode_state == ST_IDLE ##1 mode_state == ST_RUN);
    c_pdown_wake: cover property (mode_state == ST_PDOWN ##1 mode_state == ST_OSC_WAIT);
    c_reset_wake: cover property (mode_state == ST_RST_RESUME ##1 mode_state == ST_RUN);
endmodule

bind ipc_top ipc_assertions #(.PORT_W(PORT_W)) u_ipc_assertions (.core_clk, .rst_n, .clk_en,
    .reg_addr, .reg_rd, .reg_rdata, .irq_req, .irq_src_en, .irq_global_en, .cpu_clk_en,
    .periph_clk_en, .osc_en, .cpu_hold, .ram_block, .wake_irq, .port_out, .mode_state);

// ---- verif/ipc_partner.sv ----
// CPU core and oscillator model facing the controller
`timescale 1ns/1ps
module ipc_partner
    import ipc_pkg::*;
#(
    parameter int OSC_DLY = 6
) (
    input  wire logic       core_clk,   // Clock
    input  wire logic       rst_n,      // Sync reset
    input  wire logic       reg_wr,     // Software store
    input  wire logic [7:0] reg_addr,   // Store address
    input  wire logic       osc_en,     // Oscillator run request
    output logic            instr_done, // Instruction completes
    output logic            osc_ready   // Oscillator stable
);
    logic [3:0] osc_cnt_ff;

    // Store to the power register completes the instruction
    always_ff @(posedge core_clk)
        instr_done <= rst_n && reg_wr && reg_addr == PWR_CTRL_ADDR;

    // Slow start after every stop
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || !osc_en)
            osc_cnt_ff <= 4'h0;
        else if (osc_cnt_ff != 4'(OSC_DLY))
            osc_cnt_ff <= osc_cnt_ff + 4'h1;
    end
    assign osc_ready = osc_cnt_ff == 4'(OSC_DLY);
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
module testbench
    import ipc_pkg::*;
;
    logic       core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic       rst_pin = 1'h0, external_irq_zero_n = 1'h1, external_irq_one_n = 1'h1;
    logic       irq_req = 1'h0, irq_src_en = 1'h0, irq_global_en = 1'h0;
    logic       adc_idle_req = 1'h0, adc_done = 1'h0;
    logic [1:0] ext_irq_en = 2'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port_latch = 8'ha5;
    logic [7:0] reg_rdata, port_out, port_oe_n;
    logic [2:0] mode_state;
    logic       instr_done, osc_ready, cpu_clk_en, periph_clk_en, osc_en, cpu_hold;
    logic       ram_block, sfr_reset, int_rst, wake_irq;
    int         fail_count = 0;
    int         total_checks = 0;

    ipc_top #(.PORT_W(8)) dut (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .instr_done, .rst_pin, .external_irq_zero_n,
        .external_irq_one_n, .ext_irq_en, .irq_req, .irq_src_en, .irq_global_en,
        .adc_idle_req, .adc_done, .osc_ready, .port_latch, .cpu_clk_en, .periph_clk_en,
        .osc_en, .cpu_hold, .ram_block, .sfr_reset, .int_rst, .wake_irq, .port_out,
        .port_oe_n, .mode_state);
    ipc_partner u_partner (.core_clk, .rst_n, .reg_wr, .reg_addr, .osc_en, .instr_done,
        .osc_ready);

    always #25 core_clk = ~core_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 check(reg_rdata, exp);
    endtask

    task automatic wait_mode(input ipc_state_t st);
        repeat (200)
            if (mode_state !== st)
                @(posedge core_clk) #1;
        check({5'h0, mode_state}, {5'h0, st});
    endtask

    task automatic test_done;
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #(CLK_PERIOD_NS * 4000);
        fail_count++;
        test_done();
    end

    initial
    begin
        repeat (16) @(posedge core_clk);
        #1 check(port_out, PORT_RESET_VAL);
        @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (40) @(posedge core_clk);
        rd(PWR_CTRL_ADDR, PWR_CTRL_RESET);
        wr(PWR_CTRL_ADDR, 8'he0);
        rd(PWR_CTRL_ADDR, 8'hc0);
        rd(8'h86, 8'h00);
        // Idle: a globally masked source must not wake
        wr(PWR_CTRL_ADDR, 8'hcd);
        wait_mode(ST_IDLE);
        check({6'h0, cpu_clk_en, periph_clk_en}, 8'h01);
        check(port_out, port_latch);
        check(port_oe_n, 8'h00);
        @(posedge core_clk);
        irq_req <= 1'h1;
        irq_src_en <= 1'h1;
        repeat (10) @(posedge core_clk);
        #1 check({5'h0, mode_state}, {5'h0, ST_IDLE});
        @(posedge core_clk);
        irq_global_en <= 1'h1;
        wait_mode(ST_RUN);
        check({7'h0, wake_irq}, 8'h01);
        @(posedge core_clk);
        irq_req <= 1'h0;
        irq_global_en <= 1'h0;
        rd(PWR_CTRL_ADDR, 8'hcc);
        // Frozen clock enable ignores a write
        @(posedge core_clk);
        clk_en <= 1'h0;
        wr(PWR_CTRL_ADDR, 8'h00);
        clk_en <= 1'h1;
        rd(PWR_CTRL_ADDR, 8'hcc);
        // Both request bits: power-down, external wake
        ext_irq_en <= 2'h1;
        wr(PWR_CTRL_ADDR, 8'hcf);
        wait_mode(ST_PDOWN);
        check({5'h0, osc_en, cpu_clk_en, periph_clk_en}, 8'h00);
        check(port_out, port_latch);
        @(posedge core_clk);
        external_irq_zero_n <= 1'h0;
        wait_mode(ST_IRQ_HOLD);
        repeat (8) @(posedge core_clk);
        #1 check({7'h0, cpu_hold}, 8'h01);
        @(posedge core_clk);
        external_irq_zero_n <= 1'h1;
        wait_mode(ST_RUN);
        check({7'h0, wake_irq}, 8'h01);
        repeat (6) @(posedge core_clk);
        #1 check({5'h0, mode_state}, {5'h0, ST_RUN});
        rd(PWR_CTRL_ADDR, 8'hcc);
        // Converter-requested idle ends on completion
        adc_idle_req <= 1'h1;
        wr(PWR_CTRL_ADDR, 8'hcd);
        wait_mode(ST_IDLE);
        @(posedge core_clk);
        adc_done <= 1'h1;
        @(posedge core_clk);
        adc_done <= 1'h0;
        adc_idle_req <= 1'h0;
        wait_mode(ST_RUN);
        // Reset pin out of idle, then out of power-down
        for (int i = 0; i < 2; i++)
        begin
            wr(PWR_CTRL_ADDR, i ? 8'hce : 8'hcd);
            wait_mode(i ? ST_PDOWN : ST_IDLE);
            @(posedge core_clk);
            rst_pin <= 1'h1;
            wait_mode(ST_RST_RESUME);
            check({6'h0, ram_block, cpu_clk_en}, 8'h03);
            wait_mode(ST_RUN);
            check(port_out, PORT_RESET_VAL);
            check({6'h0, int_rst, sfr_reset}, 8'h03);
            @(posedge core_clk);
            rst_pin <= 1'h0;
            repeat (WARM_RST_CYC + 10) @(posedge core_clk);
            rd(PWR_CTRL_ADDR, PWR_CTRL_RESET & 8'hef);
            check({6'h0, int_rst, sfr_reset}, 8'h00);
        end
        test_done();
    end
endmodule
